// *** shared/ewg_map.vh ***
`ifndef EWG_MAP_VH
`define EWG_MAP_VH
// ----------------------------------------------------------------
// Register map (byte addresses, one word each)
// ----------------------------------------------------------------
`define EWG_ADDR_W 4
`define EWG_REG_CTRL 4'h0
`define EWG_REG_STAT 4'h4
`define EWG_REG_UNLOCK 4'h8
`define EWG_REG_WDCFG 4'hc
// CTRL fields
`define EWG_CTRL_WEL 0
`define EWG_CTRL_WEL_CLR 1
// STAT fields
`define EWG_STAT_WEL 0
`define EWG_STAT_BUSY 1
`define EWG_STAT_STANDBY 2
`define EWG_STAT_RESET 3
`define EWG_STAT_UNLOCKED 4
`define EWG_STAT_REFUSED 5
// Unlock keys, three steps
`define EWG_KEY1 8'h5a
`define EWG_KEY2 8'ha5
`define EWG_KEY3 8'h3c
`define EWG_WDCFG_RST 8'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EWG_CLK_NS 5
`define EWG_PURST_NS 50000000
`define EWG_PURST_CYC (`EWG_PURST_NS / `EWG_CLK_NS)
`define EWG_WC_NS 5000000
`define EWG_WC_CYC (`EWG_WC_NS / `EWG_CLK_NS)
`define EWG_MEM_AW 9
`endif

// *** hdl/ewg_timer.v ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Down counter: busy from start until count reaches zero
// ----------------------------------------------------------------
module ewg_timer (
  input wire clk,
  input wire rst,
  input wire start,
  input wire [31:0] load,
  output wire busy
);
  reg [31:0] cnt_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 32'h0;
    end else if (start) begin
      cnt_r <= load;
    end else if (cnt_r != 32'h0) begin
      cnt_r <= cnt_r - 32'h1;
    end
  end
  assign busy = (cnt_r != 32'h0);
endmodule // ewg_timer

// *** hdl/ewg_guard.v ***
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/10ps
`include "ewg_map.vh"
// What this block does
// - After reset the device sits in standby until any start condition arrives, whatever the address.
// - The write enable latch clears at reset and while clear every two-wire array or control write is refused.
// - At reset the data line driver is released so the device only receives.
// - The system reset output stays asserted for the power-up reset time after reset.
// - Two-wire writes are accepted only while the write enable latch is set, which the master sets first.
// - A write cycle starts at stop only if the right clock count and bit sequence came before it.
// - Control writes changing watchdog or protection need a three-step unlock first, else refused.
// - While the protect input is high every array and register write is blocked.
// - A stop mid-byte or before one full data byte and acknowledge drops the transaction unchanged.
// - During the internal write cycle the device does not acknowledge its slave address.
module ewg_guard #(
  parameter PURST_CYC = `EWG_PURST_CYC,
  parameter WC_CYC = `EWG_WC_CYC
) (
  input wire MCLK,
  input wire RST,
  input wire [3:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [31:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  input wire SCL,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  input wire WP,
  output wire SYS_RESET,
  output reg MEM_WE,
  output reg [8:0] MEM_ADDR,
  output reg [7:0] MEM_WDATA,
  output reg [7:0] WDCFG
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 6'b000001;
  localparam ST_DEV = 6'b000010;
  localparam ST_ADDR = 6'b000100;
  localparam ST_DATA = 6'b001000;
  localparam ST_ACK = 6'b010000;
  localparam ST_IGN = 6'b100000;

  reg [5:0] st_r;
  reg [5:0] st_nxt;
  reg scl_d_r, sda_d_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg ctl_sel_r, a8_r, is_rd_r;
  reg [5:0] ack_from_r;
  reg got_data_r;
  reg [7:0] wbyte_r;
  reg [8:0] waddr_r;
  reg ack_r;
  reg wel_r, unlocked_r, refused_r;
  reg [1:0] key_step_r;
  reg wc_start_r;
  reg wc_is_ctl_r;
  reg ack_q_r;
  wire wc_busy;
  wire purst_busy;
  reg first_r;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  ewg_timer u_purst (
    .clk(MCLK),
    .rst(RST),
    .start(first_r),
    .load(PURST_CYC),
    .busy(purst_busy)
  );
  ewg_timer u_wc (
    .clk(MCLK),
    .rst(RST),
    .start(wc_start_r),
    .load(WC_CYC),
    .busy(wc_busy)
  );

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end
  // The first edge after reset loads the timer, so first_r covers that edge
  assign SYS_RESET = first_r | purst_busy;

  // ----------------------------------------------------------------
  // Two-wire line decode
  // ----------------------------------------------------------------
  wire scl_rise = SCL & ~scl_d_r;
  wire scl_fall = ~SCL & scl_d_r;
  // Start and stop are data line edges while the clock stays high
  wire start_c = SCL & scl_d_r & sda_d_r & ~SDA_IN;
  wire stop_c = SCL & scl_d_r & ~sda_d_r & SDA_IN;
  wire [7:0] byte_in = {sh_r[6:0], SDA_IN};
  // Only an open-drain low is driven; released otherwise
  assign SDA_OUT = 1'b0;
  assign SDA_OE = ack_r;

  function key_of;
    input [1:0] step;
    input [7:0] val;
    begin
      case (step)
        2'd0: key_of = (val == `EWG_KEY1);
        2'd1: key_of = (val == `EWG_KEY2);
        default: key_of = (val == `EWG_KEY3);
      endcase
    end
  endfunction

  // Write allowed only with latch set, pin low, and unlock for control
  wire write_ok = wel_r & ~WP & (~ctl_sel_r | unlocked_r);

  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: st_nxt = st_r;
      ST_DEV: if (bit_r == 4'd8 && scl_rise) st_nxt = ST_ACK;
      ST_ADDR: if (bit_r == 4'd8 && scl_rise) st_nxt = ST_ACK;
      ST_DATA: if (bit_r == 4'd8 && scl_rise) st_nxt = ST_ACK;
      ST_ACK: st_nxt = st_r;
      ST_IGN: st_nxt = st_r;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_r <= ST_IDLE;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ctl_sel_r <= 1'b0;
      a8_r <= 1'b0;
      is_rd_r <= 1'b0;
      ack_from_r <= ST_IDLE;
      got_data_r <= 1'b0;
      wbyte_r <= 8'h00;
      waddr_r <= 9'h000;
      ack_r <= 1'b0;
      wc_start_r <= 1'b0;
      wc_is_ctl_r <= 1'b0;
      ack_q_r <= 1'b0;
    end else begin
      scl_d_r <= SCL;
      sda_d_r <= SDA_IN;
      wc_start_r <= 1'b0;
      if (start_c) begin
        st_r <= ST_DEV;
        bit_r <= 4'h0;
        got_data_r <= 1'b0;
        ack_r <= 1'b0;
      end else if (stop_c) begin
        // Partial byte or no acked data byte: nothing written
        // The clock rise ahead of a stop in the data state counts as one bit, so a clean
        // stop after an acked data byte shows a count of exactly one
        if (got_data_r && st_r == ST_DATA && bit_r == 4'd1 && !is_rd_r && write_ok) begin
          wc_start_r <= 1'b1;
          wc_is_ctl_r <= ctl_sel_r;
        end
        st_r <= ST_IDLE;
        got_data_r <= 1'b0;
        ack_r <= 1'b0;
      end else begin
        if (scl_rise && (st_r == ST_DEV || st_r == ST_ADDR || st_r == ST_DATA)) begin
          sh_r <= byte_in;
          bit_r <= bit_r + 4'd1;
          if (bit_r == 4'd7) begin
            ack_from_r <= st_r;
            case (st_r)
              ST_DEV: begin
                ctl_sel_r <= byte_in[4];
                a8_r <= byte_in[1];
                is_rd_r <= byte_in[0];
                // Busy write cycle: stay silent so the master can poll
                ack_q_r <= (byte_in[7:5] == 3'b101) && (byte_in[3:2] == 2'b00) && !wc_busy;
              end
              ST_ADDR: begin
                waddr_r <= {a8_r, byte_in};
                ack_q_r <= 1'b1;
              end
              ST_DATA: begin
                wbyte_r <= byte_in;
                ack_q_r <= 1'b1;
              end
              default: ack_q_r <= 1'b0;
            endcase
          end
        end
        if (scl_fall && bit_r == 4'd8 && st_r != ST_ACK) begin
          st_r <= ST_ACK;
          ack_r <= ack_q_r;
        end else if (scl_fall && st_r == ST_ACK) begin
          ack_r <= 1'b0;
          bit_r <= 4'h0;
          if (!ack_q_r) begin
            st_r <= ST_IGN;
          end else if (ack_from_r == ST_DEV) begin
            st_r <= is_rd_r ? ST_IGN : ST_ADDR;
          end else begin
            st_r <= ST_DATA;
            if (ack_from_r == ST_DATA) begin
              got_data_r <= 1'b1;
            end
          end
        end else if (st_nxt != st_r) begin
          st_r <= st_nxt;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile commit at the start of the write cycle
  // ----------------------------------------------------------------
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      MEM_WE <= 1'b0;
      MEM_ADDR <= 9'h000;
      MEM_WDATA <= 8'h00;
      WDCFG <= `EWG_WDCFG_RST;
    end else begin
      // Only the last data byte is kept; there is no page buffer
      MEM_WE <= wc_start_r & ~wc_is_ctl_r;
      if (wc_start_r) begin
        MEM_ADDR <= waddr_r;
        MEM_WDATA <= wbyte_r;
      end
      if (wc_start_r && wc_is_ctl_r) begin
        WDCFG <= wbyte_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait state on reads
  // ----------------------------------------------------------------
  reg rd_done_r;
  wire bus_wr = AVS_WRITE & AVS_BYTEENABLE[0];
  // Writes finish at once; reads wait one cycle as the read data is registered
  assign AVS_WAITREQUEST = AVS_READ & ~rd_done_r;
  wire reg_wr_ok = bus_wr & ~WP;

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wel_r <= 1'b0;
      unlocked_r <= 1'b0;
      key_step_r <= 2'd0;
      refused_r <= 1'b0;
      rd_done_r <= 1'b0;
      AVS_READDATA <= 32'h0;
    end else begin
      rd_done_r <= AVS_READ & ~rd_done_r;
      if (AVS_READ && !rd_done_r) begin
        case (AVS_ADDRESS)
          `EWG_REG_CTRL: AVS_READDATA <= {31'h0, wel_r};
          `EWG_REG_STAT: AVS_READDATA <= {26'h0, refused_r, unlocked_r, SYS_RESET,
                                          (st_r == ST_IDLE), wc_busy, wel_r};
          `EWG_REG_WDCFG: AVS_READDATA <= {24'h0, WDCFG};
          default: AVS_READDATA <= 32'h0;
        endcase
      end
      if (reg_wr_ok && AVS_ADDRESS == `EWG_REG_CTRL) begin
        if (AVS_WRITEDATA[`EWG_CTRL_WEL_CLR]) begin
          wel_r <= 1'b0;
        end else if (AVS_WRITEDATA[`EWG_CTRL_WEL]) begin
          wel_r <= 1'b1;
        end
      end
      if (reg_wr_ok && AVS_ADDRESS == `EWG_REG_UNLOCK) begin
        if (key_of(key_step_r, AVS_WRITEDATA[7:0])) begin
          key_step_r <= (key_step_r == 2'd2) ? 2'd0 : key_step_r + 2'd1;
          if (key_step_r == 2'd2) begin
            unlocked_r <= 1'b1;
          end
        end else begin
          key_step_r <= 2'd0;
        end
      end
      // Unlock is spent by one control write
      if (wc_start_r && wc_is_ctl_r) begin
        unlocked_r <= 1'b0;
      end
      // A refusal in the clearing cycle wins; the clear is a register write, so the pin blocks it too
      if (stop_c && got_data_r && !is_rd_r && !write_ok) begin
        refused_r <= 1'b1;
      end else if (reg_wr_ok && AVS_ADDRESS == `EWG_REG_STAT && AVS_WRITEDATA[`EWG_STAT_REFUSED]) begin
        refused_r <= 1'b0;
      end
    end
  end
endmodule // ewg_guard

// *** verif/ewg_i2c_master.sv ***
`timescale 1ns/10ps
// ----
// Two-wire master; SCL idles high and SDA is released between frames
// ----
module ewg_i2c_master #(parameter int Q = 4) (
  input logic clk,
  input logic sda,
  output logic scl = 1'b1,
  output logic sda_low = 1'b0
);
  task automatic q();
    repeat (Q) @(posedge clk);
  endtask
  task automatic start();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_low <= !b;
    q();
    scl <= 1'b1;
    q();
    s = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  // Fewer than 8 bits leaves the byte cut short, with no acknowledge slot
  task automatic send(input logic [7:0] v, input int n, output logic ack);
    logic s;
    for (int i = 0; i < n; i++) bit_io(v[7-i], s);
    s = 1'b1;
    if (n == 8) bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
    q();
  endtask
endmodule // ewg_i2c_master

// *** verif/ewg_guard_props.sv ***
`timescale 1ns/10ps
`include "ewg_map.vh"
// ----
// Port checker for the write guard
// ----
module ewg_guard_props #(parameter PURST_CYC = 20, parameter WC_CYC = 50) (
  input logic MCLK,
  input logic RST,
  input logic [3:0] AVS_ADDRESS,
  input logic AVS_WRITE,
  input logic [31:0] AVS_WRITEDATA,
  input logic [3:0] AVS_BYTEENABLE,
  input logic SCL,
  input logic SDA_IN,
  input logic SDA_OE,
  input logic WP,
  input logic SYS_RESET,
  input logic MEM_WE,
  input logic [7:0] WDCFG
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  logic [31:0] up_r, wc_r;
  logic [3:0] stop_age_r;
  logic wel_r, frame_r, scl_q_r, sda_q_r;
  wire stop_ev = scl_q_r && SCL && !sda_q_r && SDA_IN;
  wire start_ev = scl_q_r && SCL && sda_q_r && !SDA_IN;
  // Busy window is shortened a little so sync delays in the design never trip it
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      up_r <= 32'h0;
      wc_r <= 32'h0;
      stop_age_r <= 4'hf;
      wel_r <= 1'b0;
      frame_r <= 1'b0;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= SCL;
      sda_q_r <= SDA_IN;
      up_r <= (up_r == 32'hffffffff) ? up_r : up_r + 32'h1;
      stop_age_r <= stop_ev ? 4'h0 : ((stop_age_r == 4'hf) ? stop_age_r : stop_age_r + 4'h1);
      frame_r <= start_ev ? 1'b1 : (stop_ev ? 1'b0 : frame_r);
      wc_r <= MEM_WE ? WC_CYC - 8 : ((wc_r != 32'h0) ? wc_r - 32'h1 : wc_r);
      if (AVS_WRITE && !WP && AVS_ADDRESS == `EWG_REG_CTRL && AVS_BYTEENABLE[0])
        wel_r <= AVS_WRITEDATA[1] ? 1'b0 : (AVS_WRITEDATA[0] ? 1'b1 : wel_r);
    end
  end
  sda_release_a: assert property ($past(RST) |-> !SDA_OE) else $error("data line driven after reset");
  standby_idle_a: assert property (SDA_OE |-> frame_r) else $error("data line driven outside a frame");
  purst_hold_a: assert property (up_r <= PURST_CYC |-> SYS_RESET) else $error("system reset released early");
  purst_end_a: assert property (up_r > PURST_CYC + 2 |-> !SYS_RESET) else $error("system reset held too long");
  latch_gate_a: assert property (MEM_WE |-> wel_r) else $error("array write with latch clear");
  commit_stop_a: assert property (MEM_WE |-> stop_age_r <= 8) else $error("array write not after a stop");
  wp_block_a: assert property (WP [*4] |-> !MEM_WE && $stable(WDCFG)) else $error("write while protected");
  busy_nack_a: assert property (wc_r != 32'h0 |-> !SDA_OE) else $error("acknowledge during write cycle");
  wdcfg_stop_a: assert property ($changed(WDCFG) |-> stop_age_r <= 8 && !WP) else $error("control byte changed");
  cover property (MEM_WE);
  cover property ($changed(WDCFG));
  cover property (SDA_OE);
  cover property ($fell(SYS_RESET));
endmodule // ewg_guard_props
bind ewg_guard ewg_guard_props #(.PURST_CYC(PURST_CYC), .WC_CYC(WC_CYC)) u_props (
  .MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OE(SDA_OE), .WP(WP),
  .SYS_RESET(SYS_RESET), .MEM_WE(MEM_WE), .WDCFG(WDCFG));

// *** verif/testbench.sv ***
`timescale 1ns/10ps
`include "ewg_map.vh"
// ----
// Bench: register bus and two-wire traffic
// ----
module testbench;
  logic MCLK = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0, WP = 0;
  logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
  logic AVS_WAITREQUEST, SDA_OUT, SDA_OE, SYS_RESET, MEM_WE, scl, m_low, ack, a2;
  logic [8:0] MEM_ADDR, wa;
  logic [7:0] MEM_WDATA, WDCFG, wd;
  int err_count = 0, check_count = 0, we_n = 0, n;
  // Pull-up: the line is low only while some party pulls it
  wire sda = !(m_low || (SDA_OE && !SDA_OUT));
  always #2.5 MCLK = ~MCLK;
  ewg_guard #(.PURST_CYC(20), .WC_CYC(400)) DUT (.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .SCL(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
    .SDA_OE(SDA_OE), .WP(WP), .SYS_RESET(SYS_RESET), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .WDCFG(WDCFG));
  ewg_i2c_master #(.Q(4)) m (.clk(MCLK), .sda(sda), .scl(scl), .sda_low(m_low));
  always @(posedge MCLK) if (MEM_WE === 1'b1) begin
    we_n++;
    wa = MEM_ADDR;
    wd = MEM_WDATA;
  end
  task automatic complete_run();
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int k;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= rd;
    AVS_WRITE <= !rd;
    k = 0;
    do begin
      @(posedge MCLK);
      k++;
    end while (AVS_WAITREQUEST !== 1'b0 && k < 50);
    if (k >= 50) begin
      err_count++;
      complete_run();
    end
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic xfer(input logic [7:0] dev, input logic [7:0] adr, input logic [7:0] dat, input int nb);
    m.start();
    m.send(dev, 8, ack);
    m.send(adr, 8, a2);
    m.send(dat, nb, a2);
    m.stop();
    repeat (12) @(posedge MCLK);
  endtask
  task automatic wait_idle();
    n = 0;
    do begin
      bus(1'b1, `EWG_REG_STAT, 32'h0);
      n++;
    end while (q[`EWG_STAT_BUSY] !== 1'b0 && n < 200);
    if (q[`EWG_STAT_BUSY] !== 1'b0) begin
      err_count++;
      complete_run();
    end
  endtask
  initial begin
    repeat (100000) @(posedge MCLK);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    check(SDA_OE, 1'b0);
    check(SDA_OUT, 1'b0);
    bus(1'b1, `EWG_REG_STAT, 32'h0);
    check(q & 32'h3f, 32'h0c);
    n = 0;
    while (SYS_RESET !== 1'b0 && n < 100) begin
      @(posedge MCLK);
      n++;
    end
    check(n > 10 && n < 100, 1'b1);
    if (n >= 100) complete_run();
    xfer(8'ha0, 8'h12, 8'h77, 8);
    check(ack, 1'b1);
    check(we_n, 0);
    bus(1'b0, `EWG_REG_CTRL, 32'h1);
    xfer(8'ha0, 8'h12, 8'h77, 8);
    check(we_n, 1);
    check(wa, 9'h012);
    check(wd, 8'h77);
    m.start();
    m.send(8'ha0, 8, ack);
    m.stop();
    check(ack, 1'b0);
    wait_idle();
    for (int k = 0; k < 2; k++) xfer(8'ha0, 8'h20, 8'h99, k * 4);
    check(we_n, 1);
    m.start();
    m.send(8'ha0, 8, ack);
    m.send(8'h21, 8, a2);
    m.send(8'h5e, 8, a2);
    m.send(8'h5e, 3, a2);
    m.stop();
    repeat (12) @(posedge MCLK);
    check(ack, 1'b1);
    check(we_n, 1);
    xfer(8'h60, 8'h22, 8'h33, 8);
    check(ack, 1'b0);
    check(we_n, 1);
    WP <= 1'b1;
    bus(1'b0, `EWG_REG_CTRL, 32'h2);
    xfer(8'ha0, 8'h30, 8'h11, 8);
    bus(1'b1, `EWG_REG_STAT, 32'h0);
    check(q & 32'h21, 32'h21);
    check(we_n, 1);
    WP <= 1'b0;
    xfer(8'hb2, 8'hff, 8'h55, 8);
    check(WDCFG, 8'h00);
    bus(1'b0, `EWG_REG_UNLOCK, `EWG_KEY1);
    bus(1'b0, `EWG_REG_UNLOCK, `EWG_KEY2);
    bus(1'b0, `EWG_REG_UNLOCK, `EWG_KEY3);
    bus(1'b1, `EWG_REG_STAT, 32'h0);
    check(q & 32'h10, 32'h10);
    xfer(8'hb2, 8'hff, 8'h55, 8);
    check(WDCFG, 8'h55);
    bus(1'b0, `EWG_REG_WDCFG, 32'h99);
    bus(1'b1, `EWG_REG_WDCFG, 32'h0);
    check(q & 32'hff, 32'h55);
    bus(1'b1, 4'h2, 32'h0);
    check(q, 32'h0);
    bus(1'b0, `EWG_REG_STAT, 32'h20);
    bus(1'b1, `EWG_REG_STAT, 32'h0);
    check(q & 32'h30, 32'h00);
    complete_run();
  end
endmodule // testbench
